// file: logic/sfe_erase.sv
`timescale 1ns/1ns
// Contract
// - A block erase clears exactly one 64 KByte block and leaves the others alone.
// - The write latch clears by itself when a block erase finishes.
// - The write latch clears by itself when a chip erase finishes.
// - A block-erase frame is the opcode and three address bytes while select is low.
// - A chip-erase frame is the opcode alone.
// - A block erase starts when select rises after its frame, else it is dropped.
// - A chip erase starts when select rises right after the opcode, else it is dropped.
// - A chip erase clears every location of the array, one block per cycle.
// - Erase timing runs from the core clock with no serial clock needed.
// - During an erase every command except the status read is ignored.
// - The busy bit is 1 during an erase and 0 after it.
// - Erasing sets all bits of the region to 1.
module sfe_erase #(
  parameter int ERASE_CYCLES = sfe_pkg::ERASE_CYCLES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // Serial link pins
  input  wire logic sel_b,
  input  wire logic sck,
  input  wire logic serial_data_io,
  output logic      so,
  output logic      so_oe,
  // Array view and status
  input  wire logic [sfe_pkg::BLOCK_W-1:0] blk_query,
  output logic      [7:0]                  blk_fill,
  output logic                             operation_in_progress,
  output logic                             write_enable_latch
);

  localparam int NB = 2**sfe_pkg::BLOCK_W;

  // Two-stage synchronisers; stage one is read only by stage two
  sfe_pkg::sfe_link_s sy1_r, sy2_r, prev_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sy1_r  <= '{sel_b: 1'b1, sck: 1'b0, sdi: 1'b0};
      sy2_r  <= '{sel_b: 1'b1, sck: 1'b0, sdi: 1'b0};
      prev_r <= '{sel_b: 1'b1, sck: 1'b0, sdi: 1'b0};
    end else begin
      sy1_r  <= '{sel_b: sel_b, sck: sck, sdi: serial_data_io};
      sy2_r  <= sy1_r;
      prev_r <= sy2_r;
    end
  end

  // Edge detection on synchronised pins
  wire sck_rise = sy2_r.sck & ~prev_r.sck;
  wire sck_fall = ~sy2_r.sck & prev_r.sck;
  wire sel_rise = sy2_r.sel_b & ~prev_r.sel_b;
  wire sel_fall = ~sy2_r.sel_b & prev_r.sel_b;
  wire active   = ~sy2_r.sel_b;

  // Frame shifter
  logic [31:0] shift_r;
  logic [5:0]  nbits_r;
  logic [5:0]  nbits_nxt;
  logic [31:0] shift_nxt;
  assign shift_nxt = {shift_r[30:0], sy2_r.sdi};
  assign nbits_nxt = (nbits_r == 6'h3f) ? nbits_r : nbits_r + 6'h01;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shift_r <= '0;
      nbits_r <= '0;
    end else if (sel_fall) begin
      nbits_r <= '0;
    end else if (active && sck_rise) begin
      shift_r <= shift_nxt;
      nbits_r <= nbits_nxt;
    end
  end

  // Command decode at select rise; exact bit counts enforce frame shape
  wire [7:0] opc8  = shift_r[7:0];
  wire [7:0] opc32 = shift_r[31:24];
  wire is_set_write_latch_cmd  = sel_rise && nbits_r == 6'd8 && opc8 == sfe_pkg::CMD_SET_WRITE_LATCH;
  wire is_blk   = sel_rise && nbits_r == 6'(sfe_pkg::FRAME_BITS_B)
                  && opc32 == sfe_pkg::CMD_ERASE_64K;
  wire is_chip  = sel_rise && nbits_r == 6'(sfe_pkg::FRAME_BITS_C)
                  && opc8 == sfe_pkg::CMD_ERASE_ARRAY;
  wire [sfe_pkg::BLOCK_W-1:0] blk_sel =
    shift_r[sfe_pkg::BLOCK_SHIFT +: sfe_pkg::BLOCK_W];

  // Erase sequencer
  sfe_pkg::sfe_state_e state_r, state_nxt;
  logic [31:0] cnt_r;
  logic        chip_r;
  logic [sfe_pkg::BLOCK_W-1:0] tgt_r;
  logic        wel_r;
  wire busy     = (state_r == sfe_pkg::SFE_ERASE);
  wire start    = ~busy && wel_r && (is_blk || is_chip);
  wire done     = busy && (cnt_r == 32'(ERASE_CYCLES - 1));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sfe_pkg::SFE_IDLE:  if (start) state_nxt = sfe_pkg::SFE_ERASE;
      sfe_pkg::SFE_ERASE: if (done)  state_nxt = sfe_pkg::SFE_IDLE;
      default:            state_nxt = sfe_pkg::SFE_IDLE;
    endcase
  end

  // Timer runs off core clock only, no serial activity needed
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= sfe_pkg::SFE_IDLE;
      cnt_r   <= '0;
      chip_r  <= 1'b0;
      tgt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (start || done) ? 32'h0000_0000 : (busy ? cnt_r + 32'h0000_0001 : cnt_r);
      if (start) begin
        chip_r <= is_chip;
        tgt_r  <= blk_sel;
      end
    end
  end

  // Write latch: set by command when idle, cleared by erase completion
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b)               wel_r <= 1'b0;
    else if (done)            wel_r <= 1'b0;
    else if (is_set_write_latch_cmd && !busy) wel_r <= 1'b1;
  end

  // Array write-back at completion, one block per cycle for a chip erase
  logic       wipe_r;
  logic [sfe_pkg::BLOCK_W-1:0] wipe_idx_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wipe_r     <= 1'b0;
      wipe_idx_r <= '0;
    end else if (done) begin
      wipe_r     <= 1'b1;
      wipe_idx_r <= chip_r ? '0 : tgt_r;
    end else if (wipe_r) begin
      wipe_r     <= chip_r && (wipe_idx_r != sfe_pkg::BLOCK_W'(NB - 1));
      wipe_idx_r <= wipe_idx_r + sfe_pkg::BLOCK_W'(1);
    end
  end

  // Block memory: a word per block, 8'hff means fully erased
  sfe_block_mem #(.AW(sfe_pkg::BLOCK_W), .DW(8)) u_mem (
    .clock  (clock),
    .rst_b  (rst_b),
    .wr_en  (wipe_r),
    .wr_addr(wipe_idx_r),
    .wr_data(8'hff),
    .rd_addr(blk_query),
    .rd_data(blk_fill)
  );

  // Status read output: shift status MSb first on falling edges
  wire       is_status_read_cmd = active && nbits_r == 6'd8 && opc8 == sfe_pkg::CMD_STATUS_READ;
  wire [7:0] status  = 8'({wel_r, busy});
  logic [7:0] sout_r;
  logic       soe_r;
  logic       rd_arm_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sout_r   <= '0;
      soe_r    <= 1'b0;
      rd_arm_r <= 1'b0;
    end else if (!active) begin
      soe_r    <= 1'b0;
      rd_arm_r <= 1'b0;
    end else if (is_status_read_cmd && !rd_arm_r) begin
      rd_arm_r <= 1'b1;
      sout_r   <= status;
    end else if (rd_arm_r && sck_fall) begin
      soe_r  <= 1'b1;
      sout_r <= soe_r ? {sout_r[6:0], sout_r[7]} : sout_r;
    end
  end

  assign so                    = sout_r[7];
  assign so_oe                 = soe_r;
  assign operation_in_progress = busy;
  assign write_enable_latch    = wel_r;

  // Steps of the erase completion
  sequence s_blk_done;
    done && !chip_r;
  endsequence
  sequence s_chip_done;
    done && chip_r;
  endsequence
  // Eight write cycles, one per block of the array
  sequence s_wipe_all;
    wipe_r [*8] ##1 !wipe_r;
  endsequence

  // Erase start raises busy on the next edge
  property p_start_busy;
    @(posedge clock) disable iff (!rst_b)
      start |=> operation_in_progress;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("erase did not start");

  // Completion drops busy and the write latch together
  property p_done_clear;
    @(posedge clock) disable iff (!rst_b)
      done |=> !operation_in_progress && !write_enable_latch;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("latch not cleared");

  // Erase frame without the latch is refused
  property p_locked_refuse;
    @(posedge clock) disable iff (!rst_b)
      !busy && !wel_r && (is_blk || is_chip) |=> !operation_in_progress;
  endproperty
  a_locked_refuse: assert property (p_locked_refuse) else $error("locked erase ran");

  // Busy holds and commands leave the latch alone until done
  property p_busy_hold;
    @(posedge clock) disable iff (!rst_b)
      busy && !done |=> operation_in_progress && $stable(write_enable_latch);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy disturbed");

  // Block erase writes only the addressed block
  property p_wipe_block;
    @(posedge clock) disable iff (!rst_b)
      s_blk_done |=> wipe_r && wipe_idx_r == $past(tgt_r);
  endproperty
  a_wipe_block: assert property (p_wipe_block) else $error("wrong block");

  // Chip erase walks every block once
  property p_wipe_chip;
    @(posedge clock) disable iff (!rst_b)
      s_chip_done |=> s_wipe_all;
  endproperty
  a_wipe_chip: assert property (p_wipe_chip) else $error("chip wipe short");

  // Status byte is loaded as the read opcode completes
  property p_status_load;
    @(posedge clock) disable iff (!rst_b)
      is_status_read_cmd && !rd_arm_r && !(rd_arm_r && sck_fall) |=> sout_r == $past(status);
  endproperty
  a_status_load: assert property (p_status_load) else $error("status not loaded");
endmodule // sfe_erase

// file: logic/sfe_pkg.sv
package sfe_pkg;

  // Opcodes
  localparam logic [7:0] CMD_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] CMD_ERASE_64K       = 8'hd8;
  localparam logic [7:0] CMD_ERASE_ARRAY     = 8'hc7;
  localparam logic [7:0] CMD_STATUS_READ     = 8'h05;

  // Array geometry
  localparam int ADDR_W       = 19;
  localparam int BLOCK_SHIFT  = 16;
  localparam int BLOCK_W      = ADDR_W - BLOCK_SHIFT;
  localparam int FRAME_BITS_B = 32;
  localparam int FRAME_BITS_C = 8;

  // Status bit positions
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;

  // Erase time and derived cycle count
  localparam int ERASE_TIME_MS  = 10;
  localparam int CLK_MHZ        = 100;
  localparam int ERASE_CYCLES   = ERASE_TIME_MS * 1000 * CLK_MHZ;

  // Synchronised link pins
  typedef struct packed {
    logic sel_b;
    logic sck;
    logic sdi;
  } sfe_link_s;

  typedef enum logic [1:0] {
    SFE_IDLE  = 2'b00,
    SFE_ERASE = 2'b01
  } sfe_state_e;

endpackage

// file: logic/sfe_block_mem.sv
`timescale 1ns/1ns
// Per-block erase bookkeeping: one word per 64 KByte block, registered read
module sfe_block_mem #(
  parameter int AW = 3,
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst_b,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem_r [2**AW];

  // Storage, all blocks start as holding data so an erase is visible
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 2**AW; i++) mem_r[i] <= '0;
    end else if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) rd_data <= '0;
    else        rd_data <= mem_r[rd_addr];
  end

endmodule // sfe_block_mem

// file: testbench/sfe_host.sv
`timescale 1ns/1ns
// Host SPI controller model, mode 0
module sfe_host (
  // Pacing clock
  input  wire logic clock,
  input  wire logic so,
  // Link pins
  output logic      sel_b,
  output logic      sck,
  output logic      serial_data_io
);
  // Bits seen on the status line, sampled before each rising sck
  logic [31:0] rx;
  initial begin
    rx = '0;
    sel_b = 1'b1;
    sck = 1'b0;
    serial_data_io = 1'b0;
  end
  // One frame, MSb first; 160 ns sck, idle low between frames
  task automatic send(input logic [31:0] v, input int n);
    @(negedge clock);
    sel_b = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_io = v[i];
      repeat (8) @(negedge clock);
      rx = {rx[30:0], so};
      sck = 1'b1;
      repeat (8) @(negedge clock);
      sck = 1'b0;
    end
    repeat (4) @(negedge clock);
    sel_b = 1'b1;
    // Released line must not keep the last bit
    serial_data_io = ~serial_data_io;
    repeat (8) @(negedge clock);
  endtask
endmodule // sfe_host

// file: testbench/spi_flash_block_chip_erase_test.sv
`timescale 1ns/1ns
module spi_flash_block_chip_erase_test;
  // Long enough to outlast one ignored frame
  localparam int ERASE_N = 400;
  logic                          clock;
  logic                          rst_b;
  logic                          sel_b;
  logic                          sck;
  logic                          sdi;
  logic [sfe_pkg::BLOCK_W-1:0]   blk_query;
  logic [7:0]                    blk_fill;
  logic                          busy;
  logic                          latch;
  logic [7:0]                    seed;
  logic                          so_pin;
  logic                          soe;
  logic [7:0]                    exp_map [8];
  int                            errors;
  int                            num_checks;

  sfe_host u_host (.clock(clock), .so(so_pin), .sel_b(sel_b), .sck(sck),
    .serial_data_io(sdi));
  sfe_erase #(.ERASE_CYCLES(ERASE_N)) u_dut (.clock(clock), .rst_b(rst_b), .sel_b(sel_b),
    .sck(sck), .serial_data_io(sdi), .so(so_pin), .so_oe(soe), .blk_query(blk_query),
    .blk_fill(blk_fill), .operation_in_progress(busy), .write_enable_latch(latch));

  // Clock
  always #5 clock = ~clock;

  // Pseudo-random source, fixed start
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Expected status byte: bit0 busy, bit1 latch
  function automatic logic [7:0] st(input logic b, input logic l);
    return {6'h0, l, b};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Bounded wait for busy level, then compare status
  task automatic chk_st(input logic b, input logic l, input int lim);
    for (int k = 0; k < lim && busy !== b; k++) @(negedge clock);
    chk({6'h0, latch, busy}, st(b, l), "status");
  endtask
  // Every block must match the expected erase map
  task automatic chk_fill();
    for (int b = 0; b < 8; b++) begin
      blk_query = b[2:0];
      repeat (2) @(negedge clock);
      chk(blk_fill, exp_map[b], "block fill");
    end
  endtask
  // Status read frame: opcode then eight bits clocked back
  task automatic chk_rd(input logic b, input logic l);
    u_host.send({16'h0, sfe_pkg::CMD_STATUS_READ, 8'h00}, 16);
    chk(u_host.rx[7:0], st(b, l), "status read");
    chk({7'h0, soe}, 8'h00, "drive off");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #600000;
    errors++;
    tally_and_finish();
  end

  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    blk_query = '0;
    seed = 8'h56;
    errors = 0;
    num_checks = 0;
    foreach (exp_map[j]) exp_map[j] = 8'h00;
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    chk_st(1'b0, 1'b0, 1);
    chk_fill();
    $display("test reset done");
    // Erase with latch clear is dropped
    u_host.send({sfe_pkg::CMD_ERASE_64K, 24'h01_0000}, 32);
    chk_st(1'b0, 1'b0, 1);
    u_host.send({24'h0, sfe_pkg::CMD_SET_WRITE_LATCH}, 8);
    chk_st(1'b0, 1'b1, 1);
    chk_rd(1'b0, 1'b1);
    // Frame cut short or overlong must not start
    u_host.send({8'h0, sfe_pkg::CMD_ERASE_64K, 16'h0000}, 24);
    chk_st(1'b0, 1'b1, 1);
    u_host.send({16'h0, sfe_pkg::CMD_ERASE_ARRAY, 8'h00}, 16);
    chk_st(1'b0, 1'b1, 1);
    $display("test refusals done");
    // Random block addresses, latch set attempt while busy
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      if (i > 0) u_host.send({24'h0, sfe_pkg::CMD_SET_WRITE_LATCH}, 8);
      u_host.send({sfe_pkg::CMD_ERASE_64K, seed, ~seed, seed}, 32);
      chk_st(1'b1, 1'b1, 10);
      u_host.send({24'h0, sfe_pkg::CMD_SET_WRITE_LATCH}, 8);
      chk_st(1'b1, 1'b1, 1);
      chk_rd(1'b1, 1'b1);
      chk_st(1'b0, 1'b0, ERASE_N + 20);
      exp_map[seed[2:0]] = 8'hff;
    end
    chk_fill();
    $display("test block erase done");
    u_host.send({24'h0, sfe_pkg::CMD_SET_WRITE_LATCH}, 8);
    u_host.send({24'h0, sfe_pkg::CMD_ERASE_ARRAY}, 8);
    chk_st(1'b1, 1'b1, 10);
    chk_st(1'b0, 1'b0, ERASE_N + 20);
    foreach (exp_map[j]) exp_map[j] = 8'hff;
    chk_fill();
    $display("test chip erase done");
    tally_and_finish();
  end
endmodule // spi_flash_block_chip_erase_test
